// [pkg/tws_consts.svh]
// Constants for the two-wire sensor slave interface
// Summary of operation
// - Bytes shift most significant bit first
// - Address is 1001 plus three strap pins
// - Address byte ends with read/write bit
// - Pointer byte low two bits select register
// - SDA falling while SCL high is start
// - SDA rising while SCL high is stop
// - SDA changes only while SCL is low
// - Every byte followed by one acknowledge clock
// - Receiver pulls SDA low during acknowledge
// - Write: acknowledge address, then pointer byte
// - Acknowledge write data; stop ends write
// - Read: acknowledge address, then drive data
// - Configuration read sends one byte
// - Other registers read as two bytes
// - Early NACK ends read, SDA released
// - Pointer write, repeated start, then read
// - Register selection kept between transactions
// - Repeated start begins a new operation
// - Pointer 00 temp, 01 config, 10 hyst, 11 limit
// - Selection defaults to temperature at reset
// - Completed read is signalled to thermostat
`ifndef TWS_CONSTS_SVH
`define TWS_CONSTS_SVH

`define TWS_ADDR_FIXED 4'h9
`define TWS_PTR_TEMP   2'h0
`define TWS_PTR_CONF   2'h1
`define TWS_PTR_HYST   2'h2
`define TWS_PTR_OVER   2'h3
`define TWS_PTR_RESET  2'h0
`define TWS_BIT_LAST   3'h7
`define TWS_WR_MAX     2'h2

`endif

// [pkg/tws_pkg.sv]
// Types for the two-wire sensor slave interface
package tws_pkg;

  typedef enum logic [3:0] {
    TWS_IDLE     = 4'h0,
    TWS_ADDR     = 4'h1,
    TWS_ADDR_ACK = 4'h3,
    TWS_PTR      = 4'h2,
    TWS_PTR_ACK  = 4'h6,
    TWS_WDATA    = 4'h7,
    TWS_WDAT_ACK = 4'h5,
    TWS_RDATA    = 4'h4,
    TWS_RACK     = 4'hc,
    TWS_IGNORE   = 4'hd
  } tws_state_e;

endpackage

// [hdl/tws_slave.sv]
// Two-wire bus slave of a temperature sensor with register exchange
`timescale 1ns/1ps
`include "tws_consts.svh"

module tws_slave (
  // System clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // Link clock for bus sampling
  input  wire logic        linkClk,
  // Bus pins
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe_b,
  // Address straps
  input  wire logic        addrStrap2,
  input  wire logic        addrStrap1,
  input  wire logic        addrStrap0,
  // Register contents to send
  input  wire logic [15:0] tempValue,
  input  wire logic [7:0]  configValue,
  input  wire logic [15:0] hystValue,
  input  wire logic [15:0] overTempValue,
  // Write results and status
  output logic             wrStrobe,
  output logic [1:0]       wrSelect,
  output logic [15:0]      wrData,
  output logic [1:0]       wrBytes,
  output logic [1:0]       regSelect,
  output logic             readDone
);

  // Every register but configuration moves as two bytes
  function automatic logic twoByte(input logic [1:0] sel);
    twoByte = (sel != `TWS_PTR_CONF);
  endfunction

  // ------------------------------------------------------------
  // Link domain reset and pin synchronisers
  // ------------------------------------------------------------
  logic       linkRstA_b;
  logic       linkRst_b;
  logic       sclA;
  logic       sclS;
  logic       sclD;
  logic       sdaA;
  logic       sdaS;
  logic       sdaD;
  logic [2:0] strapA;
  logic [2:0] strapS;

  // Link reset asserts at once and lets go on the link clock
  always_ff @(posedge linkClk or negedge rst_b) begin
    if (!rst_b) begin
      linkRstA_b <= 1'b0;
      linkRst_b  <= 1'b0;
    end else begin
      linkRstA_b <= 1'b1;
      linkRst_b  <= linkRstA_b;
    end
  end

  always_ff @(posedge linkClk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      sclA   <= 1'b1;
      sclS   <= 1'b1;
      sclD   <= 1'b1;
      sdaA   <= 1'b1;
      sdaS   <= 1'b1;
      sdaD   <= 1'b1;
      strapA <= 3'h0;
      strapS <= 3'h0;
    end else begin
      sclA   <= sclIn;
      sclS   <= sclA;
      sclD   <= sclS;
      sdaA   <= sdaIn;
      sdaS   <= sdaA;
      sdaD   <= sdaS;
      strapA <= {addrStrap2, addrStrap1, addrStrap0};
      strapS <= strapA;
    end
  end

  // ------------------------------------------------------------
  // Bus events
  // ------------------------------------------------------------
  logic       sclRise;
  logic       sclFall;
  logic       startSeen;
  logic       stopSeen;
  logic [7:0] rxByte;
  logic [7:0] rxShift;

  assign sclRise   = sclS & ~sclD;
  assign sclFall   = ~sclS & sclD;
  assign startSeen = sclS & sclD & sdaD & ~sdaS;
  assign stopSeen  = sclS & sclD & ~sdaD & sdaS;
  assign rxByte    = {rxShift[6:0], sdaS};

  // ------------------------------------------------------------
  // Link state machine
  // ------------------------------------------------------------
  tws_pkg::tws_state_e state;
  logic [2:0]  bitCnt;
  logic        ackPend;
  logic        masterAck;
  logic        byteIdx;
  logic [1:0]  ptr;
  logic [1:0]  wrCnt;
  logic [15:0] wrWord;
  logic        pendWr;
  logic [7:0]  txShift;
  logic        wrEvtT;
  logic        rdReqT;
  logic        rdDoneT;
  logic [15:0] snap;

  always_ff @(posedge linkClk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      state     <= tws_pkg::TWS_IDLE;
      bitCnt    <= 3'h0;
      ackPend   <= 1'b0;
      masterAck <= 1'b0;
      byteIdx   <= 1'b0;
      ptr       <= `TWS_PTR_RESET;
      wrCnt     <= 2'h0;
      wrWord    <= 16'h0000;
      pendWr    <= 1'b0;
      txShift   <= 8'h00;
      rxShift   <= 8'h00;
      wrEvtT    <= 1'b0;
      rdReqT    <= 1'b0;
      rdDoneT   <= 1'b0;
      sdaOe_b   <= 1'b1;
    end else if (startSeen || stopSeen) begin
      // Any pending write is handed over before the next operation
      if (pendWr) begin
        wrEvtT <= ~wrEvtT;
      end
      pendWr  <= 1'b0;
      bitCnt  <= 3'h0;
      ackPend <= 1'b0;
      sdaOe_b <= 1'b1;
      state   <= startSeen ? tws_pkg::TWS_ADDR
                           : tws_pkg::TWS_IDLE;
    end else if (sclRise) begin
      rxShift <= rxByte;
      bitCnt  <= bitCnt + 3'h1;
      unique case (state)
        tws_pkg::TWS_ADDR: begin
          if (bitCnt == `TWS_BIT_LAST) begin
            if (rxByte[7:1] == {`TWS_ADDR_FIXED, strapS}) begin
              state   <= tws_pkg::TWS_ADDR_ACK;
              ackPend <= 1'b1;
              byteIdx <= 1'b0;
              wrCnt   <= 2'h0;
              if (rxByte[0]) begin
                rdReqT <= ~rdReqT;
              end
              masterAck <= rxByte[0];
            end else begin
              state <= tws_pkg::TWS_IGNORE;
            end
          end
        end
        tws_pkg::TWS_PTR: begin
          if (bitCnt == `TWS_BIT_LAST) begin
            ptr     <= rxByte[1:0];
            pendWr  <= 1'b1;
            state   <= tws_pkg::TWS_PTR_ACK;
            ackPend <= 1'b1;
          end
        end
        tws_pkg::TWS_WDATA: begin
          if (bitCnt == `TWS_BIT_LAST) begin
            if (wrCnt == 2'h0) begin
              wrWord <= {rxByte, 8'h00};
            end else begin
              wrWord[7:0] <= rxByte;
            end
            wrCnt   <= wrCnt + 2'h1;
            state   <= tws_pkg::TWS_WDAT_ACK;
            ackPend <= 1'b1;
          end
        end
        tws_pkg::TWS_RDATA: begin
          if (bitCnt == `TWS_BIT_LAST) begin
            state   <= tws_pkg::TWS_RACK;
            ackPend <= 1'b1;
          end
        end
        tws_pkg::TWS_RACK: begin
          if (!ackPend) begin
            masterAck <= ~sdaS;
          end
        end
        tws_pkg::TWS_IDLE,
        tws_pkg::TWS_ADDR_ACK,
        tws_pkg::TWS_PTR_ACK,
        tws_pkg::TWS_WDAT_ACK,
        tws_pkg::TWS_IGNORE: begin
        end
        default: state <= tws_pkg::TWS_IDLE;
      endcase
    end else if (sclFall) begin
      unique case (state)
        tws_pkg::TWS_ADDR_ACK,
        tws_pkg::TWS_PTR_ACK,
        tws_pkg::TWS_WDAT_ACK: begin
          if (ackPend) begin
            ackPend <= 1'b0;
            sdaOe_b <= 1'b0;
          end else begin
            sdaOe_b <= 1'b1;
            bitCnt  <= 3'h0;
            if (state == tws_pkg::TWS_ADDR_ACK && masterAck) begin
              txShift <= snap[15:8];
              sdaOe_b <= snap[15];
              state   <= tws_pkg::TWS_RDATA;
            end else if (state == tws_pkg::TWS_ADDR_ACK) begin
              state <= tws_pkg::TWS_PTR;
            end else if (wrCnt == `TWS_WR_MAX ||
                         (wrCnt != 2'h0 && !twoByte(ptr))) begin
              state <= tws_pkg::TWS_IGNORE;
            end else begin
              state <= tws_pkg::TWS_WDATA;
            end
          end
        end
        tws_pkg::TWS_RDATA: begin
          txShift <= {txShift[6:0], 1'b0};
          sdaOe_b <= txShift[6];
        end
        tws_pkg::TWS_RACK: begin
          if (ackPend) begin
            ackPend <= 1'b0;
            sdaOe_b <= 1'b1;
          end else if (masterAck && !byteIdx && twoByte(ptr)) begin
            byteIdx <= 1'b1;
            bitCnt  <= 3'h0;
            txShift <= snap[7:0];
            sdaOe_b <= snap[7];
            state   <= tws_pkg::TWS_RDATA;
          end else begin
            rdDoneT <= ~rdDoneT;
            state   <= tws_pkg::TWS_IGNORE;
          end
        end
        tws_pkg::TWS_IDLE,
        tws_pkg::TWS_ADDR,
        tws_pkg::TWS_PTR,
        tws_pkg::TWS_WDATA,
        tws_pkg::TWS_IGNORE: begin
          sdaOe_b <= 1'b1;
        end
        default: state <= tws_pkg::TWS_IDLE;
      endcase
    end
  end

  // Line is open drain: only a low level is ever driven
  always_ff @(posedge linkClk or negedge linkRst_b) begin
    if (!linkRst_b) begin
      sdaOut <= 1'b0;
    end else begin
      sdaOut <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // System domain: event synchronisers
  // ------------------------------------------------------------
  logic [2:0] wrSync;
  logic [2:0] rdReqSync;
  logic [2:0] rdDoneSync;

  // Toggles cross one bit each; fields beside them are held still
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrSync     <= 3'h0;
      rdReqSync  <= 3'h0;
      rdDoneSync <= 3'h0;
    end else begin
      wrSync     <= {wrSync[1:0], wrEvtT};
      rdReqSync  <= {rdReqSync[1:0], rdReqT};
      rdDoneSync <= {rdDoneSync[1:0], rdDoneT};
    end
  end

  // ------------------------------------------------------------
  // System domain: read snapshot, selected by the held pointer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      snap <= 16'h0000;
    end else if (rdReqSync[2] ^ rdReqSync[1]) begin
      // Taken well before the first data bit leaves on the line
      unique case (ptr)
        `TWS_PTR_TEMP: snap <= tempValue;
        `TWS_PTR_CONF: snap <= {configValue, 8'h00};
        `TWS_PTR_HYST: snap <= hystValue;
        `TWS_PTR_OVER: snap <= overTempValue;
      endcase
    end
  end

  // ------------------------------------------------------------
  // System domain: write results and read completion
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrStrobe  <= 1'b0;
      wrSelect  <= `TWS_PTR_RESET;
      wrData    <= 16'h0000;
      wrBytes   <= 2'h0;
      regSelect <= `TWS_PTR_RESET;
    end else begin
      wrStrobe <= 1'b0;
      if (wrSync[2] ^ wrSync[1]) begin
        regSelect <= ptr;
        if (wrCnt != 2'h0) begin
          wrStrobe <= 1'b1;
          wrSelect <= ptr;
          wrData   <= wrWord;
          wrBytes  <= wrCnt;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readDone <= 1'b0;
    end else begin
      // One pulse per finished read, for the thermostat clear
      readDone <= rdDoneSync[2] ^ rdDoneSync[1];
    end
  end

endmodule // tws_slave

// [verif/tws_slave_props.sv]
// Port assertions of the two-wire sensor slave
`timescale 1ns/1ps
module tws_slave_props (
  // Clocks and reset
  input wire logic        sys_clk,
  input wire logic        linkClk,
  input wire logic        rst_b,
  // Bus side
  input wire logic        sclIn,
  input wire logic        sdaOut,
  input wire logic        sdaOe_b,
  // System side
  input wire logic        wrStrobe,
  input wire logic [1:0]  wrSelect,
  input wire logic [15:0] wrData,
  input wire logic [1:0]  wrBytes,
  input wire logic [1:0]  regSelect,
  input wire logic        readDone
);
  AST_OPEN_DRAIN:
    assert property (@(posedge linkClk) disable iff (!rst_b)
      !sdaOe_b |-> !sdaOut) else $error("sda driven high");
  AST_SDA_SCL_LOW:
    assert property (@(posedge linkClk) disable iff (!rst_b)
      $changed(sdaOe_b) |-> !sclIn) else $error("sda moved in scl high");
  AST_WR_PULSE:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrStrobe |=> !wrStrobe) else $error("write strobe too long");
  AST_RD_PULSE:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      readDone |=> !readDone) else $error("read pulse too long");
  AST_WR_BYTES:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrStrobe |-> wrBytes inside {2'h1, 2'h2}) else $error("bad count");
  AST_CONF_ONE:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrStrobe && wrSelect == 2'h1 |-> wrBytes == 2'h1 && wrData[7:0] == 8'h00)
      else $error("config write not one byte");
  AST_SEL_KEEP:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      wrStrobe |-> regSelect == wrSelect) else $error("pointer lost");
  AST_RESET_PTR:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(rst_b) |-> regSelect == 2'h0 && sdaOe_b && !wrStrobe)
      else $error("bad state after reset");
  AST_RD_SEL_HOLD:
    assert property (@(posedge sys_clk) disable iff (!rst_b)
      readDone |-> $stable(regSelect)) else $error("read moved pointer");
  cover property (@(posedge sys_clk) wrStrobe && wrBytes == 2'h2);
  cover property (@(posedge sys_clk) readDone);
  cover property (@(posedge linkClk) $fell(sdaOe_b));
endmodule // tws_slave_props

// [verif/tws_master.sv]
// Behavioural two-wire bus master for the sensor slave bench
`timescale 1ns/1ps
module tws_master #(
  parameter int Q = 300
) (
  // Bus pins
  output logic      scl,
  output logic      sdaDrv,
  input  wire logic sdaLine
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  // One SCL period; data set while SCL low
  task automatic bitClk(input logic b, output logic s);
    sdaDrv = b;
    #Q scl = 1'b1;
    #Q s = sdaLine;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start();
    sdaDrv = 1'b1;
    #Q scl = 1'b1;
    #Q sdaDrv = 1'b0;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sdaDrv = 1'b0;
    #Q scl = 1'b1;
    #Q sdaDrv = 1'b1;
    #Q;
  endtask
  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitClk(d[i], s);
    bitClk(1'b1, s);
    ack = ~s;
  endtask
  task automatic recvByte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitClk(1'b1, d[i]);
    bitClk(last, s);
  endtask
endmodule // tws_master

// [verif/tws_slave_tb.sv]
// Self-checking bench of the two-wire sensor slave
`timescale 1ns/1ps
`include "tws_consts.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  error_cnt++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tws_slave_tb;
  logic        sys_clk, rst_b, linkClk, sclIn, sdaOut, sdaOe_b, sdaDrv;
  logic        addrStrap2, addrStrap1, addrStrap0, wrStrobe, readDone;
  logic [15:0] tempValue, hystValue, overTempValue, wrData, wData;
  logic [7:0]  configValue;
  logic [1:0]  wrSelect, wrBytes, regSelect, wSel, wBytes;
  int          error_cnt, n_checks, wrCnt, rdCnt;
  wire logic   sdaIn;
  assign sdaIn = sdaDrv & (sdaOe_b | sdaOut);
  tws_slave tws_slave_i (.sys_clk(sys_clk), .rst_b(rst_b),
    .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe_b(sdaOe_b), .addrStrap2(addrStrap2), .addrStrap1(addrStrap1),
    .addrStrap0(addrStrap0), .tempValue(tempValue),
    .configValue(configValue), .hystValue(hystValue),
    .overTempValue(overTempValue), .wrStrobe(wrStrobe),
    .wrSelect(wrSelect), .wrData(wrData), .wrBytes(wrBytes),
    .regSelect(regSelect), .readDone(readDone));
  tws_master tws_master_i (.scl(sclIn), .sdaDrv(sdaDrv), .sdaLine(sdaIn));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    linkClk = 1'b0;
    #1.3;
    forever #3 linkClk = ~linkClk;
  end
  always @(negedge sys_clk) begin
    if (readDone === 1'b1) rdCnt++;
    if (wrStrobe === 1'b1) begin
      wrCnt++;
      wSel = wrSelect;
      wData = wrData;
      wBytes = wrBytes;
    end
  end
  // ----------------------------------------------------------------
  // Expectations and transfers
  // ----------------------------------------------------------------
  function automatic logic [7:0] addrByte(input logic rw, logic [6:0] flip);
    return {{`TWS_ADDR_FIXED, addrStrap2, addrStrap1, addrStrap0} ^ flip,
      rw};
  endfunction
  function automatic logic [15:0] expWord(input logic [1:0] p);
    case (p)
      `TWS_PTR_TEMP: return tempValue;
      `TWS_PTR_CONF: return {configValue, 8'h00};
      `TWS_PTR_HYST: return hystValue;
      default: return overTempValue;
    endcase
  endfunction
  task automatic wrTxn(input logic [1:0] p, input logic [15:0] d);
    logic a;
    int n;
    n = (p == `TWS_PTR_CONF) ? 1 : 2;
    wrCnt = 0;
    tws_master_i.start();
    tws_master_i.sendByte(addrByte(1'b0, 7'h00), a);
    `CHK("addrAck", 1'b1, a)
    tws_master_i.sendByte({6'h00, p}, a);
    `CHK("ptrAck", 1'b1, a)
    for (int i = 0; i < n; i++) begin
      tws_master_i.sendByte(d[15-8*i -: 8], a);
      `CHK("dataAck", 1'b1, a)
    end
    tws_master_i.stop();
    repeat (20) @(negedge sys_clk);
    `CHK("wrCnt", 1, wrCnt)
    `CHK("wrSel", p, wSel)
    `CHK("wrData", n == 1 ? {d[15:8], 8'h00} : d, wData)
    `CHK("wrBytes", n[1:0], wBytes)
  endtask
  task automatic rdTxn(input logic [1:0] p, input logic early, setPtr);
    logic        a;
    logic [7:0]  b;
    logic [15:0] e;
    rdCnt = 0;
    e = expWord(p);
    if (setPtr) begin
      tws_master_i.start();
      tws_master_i.sendByte(addrByte(1'b0, 7'h00), a);
      tws_master_i.sendByte({6'h00, p}, a);
      `CHK("ptrAck", 1'b1, a)
    end
    tws_master_i.start();
    tws_master_i.sendByte(addrByte(1'b1, 7'h00), a);
    `CHK("rdAck", 1'b1, a)
    tws_master_i.recvByte(early || p == `TWS_PTR_CONF, b);
    `CHK("rdMsb", e[15:8], b)
    if (!early && p != `TWS_PTR_CONF) begin
      tws_master_i.recvByte(1'b1, b);
      `CHK("rdLsb", e[7:0], b)
    end
    tws_master_i.stop();
    repeat (20) @(negedge sys_clk);
    `CHK("sdaRel", 1'b1, sdaOe_b)
    `CHK("rdDone", 1, rdCnt)
    `CHK("regSel", p, regSelect)
  endtask
  task automatic foreign(input logic [6:0] flip);
    logic a;
    tws_master_i.start();
    tws_master_i.sendByte(addrByte(1'b0, flip), a);
    `CHK("noAck", 1'b0, a)
    tws_master_i.sendByte(8'h00, a);
    `CHK("ignored", 1'b0, a)
    tws_master_i.stop();
  endtask
  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #3_000_000;
    error_cnt++;
    $display("[ERR] watchdog expired");
    results();
  end
  initial begin
    rst_b = 1'b0;
    {addrStrap2, addrStrap1, addrStrap0} = 3'h5;
    {tempValue, hystValue, overTempValue, configValue} = '0;
    void'($urandom(38699));
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk) rst_b = 1'b1;
    repeat (10) @(negedge sys_clk);
    `CHK("rstSel", `TWS_PTR_RESET, regSelect)
    rdTxn(`TWS_PTR_TEMP, 1'b0, 1'b0);
    for (int i = 0; i < 12; i++) begin
      @(negedge sys_clk);
      tempValue = 16'($urandom);
      hystValue = 16'($urandom);
      overTempValue = 16'($urandom);
      configValue = 8'($urandom);
      {addrStrap2, addrStrap1, addrStrap0} = 3'($urandom);
      wrTxn(i[1:0], i < 8 ? 16'($urandom) : {16{i[0]}});
      rdTxn(i[1:0], i[2], 1'b1);
      foreign(7'h01 << (i % 7));
      rdTxn(i[1:0], 1'b0, 1'b0);
    end
    results();
  end
endmodule // tws_slave_tb
bind tws_slave tws_slave_props tws_slave_props_i (.sys_clk(sys_clk),
  .linkClk(linkClk), .rst_b(rst_b), .sclIn(sclIn), .sdaOut(sdaOut),
  .sdaOe_b(sdaOe_b), .wrStrobe(wrStrobe), .wrSelect(wrSelect),
  .wrData(wrData), .wrBytes(wrBytes), .regSelect(regSelect),
  .readDone(readDone));
